// [rpd_pkg.sv]
// constants and types shared by the region permission attribute decoder
//
// Contract
// - Attribute fields govern every access in region.
// - Missing rights raise a permission fault.
// - Type 000/010 uncached encodings give ordered/device.
// - Don't-care bits never affect derived attributes.
// - Type 000 C1 B0: write-through normal memory.
// - Type 000 C1 B1: write-back normal memory.
// - Type 001 decodes four cacheable/bufferable cases.
// - Type top bit: normal, two policy pairs.
// - Policy code: none, WB-alloc, WT, WB.
// - Permission code per privilege; 011 full.
// - Permission 000 faults every access.
// - Permission 001: privileged only.
// - Permission 010: unprivileged writes fault.
// - Permission 101: privileged reads only.
// - Permission 110/111: reads only, writes fault.
// - Violation signals fault and records cause.
// - Region select, base, size, attribute offsets.
// - Alias base/attribute pairs program four regions.
// - Base write with valid sets region number.
// - Exception entry and return act as barriers.
// - Register writes are strongly ordered, take effect.
// - Highest-numbered matching region wins.
// - Eight regions, one unified map.
// - Regions from 256 bytes have subregion disables.
package rpd_pkg;
    // ==========================================
    // register addresses
    localparam logic [31:0] ADDR_TYPE = 32'he000ed90;
    localparam logic [31:0] ADDR_CTRL = 32'he000ed94;
    localparam logic [31:0] ADDR_SEL = 32'he000ed98;
    localparam logic [31:0] ADDR_BASE = 32'he000ed9c;
    localparam logic [31:0] ADDR_ATTR = 32'he000eda0;
    localparam logic [31:0] ADDR_ALIAS_END = 32'he000edb8;
    localparam logic [31:0] ADDR_FSTAT = 32'he000ed28;
    // ==========================================
    // reset and fixed values
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [31:0] TYPE_VAL = 32'h00000800;
    localparam logic [31:0] ATTR_MASK = 32'h173fff3f;
    // ==========================================
    // attribute and size field positions
    localparam int XN_B = 28;
    localparam int AP_LSB = 24;
    localparam int TEX_LSB = 19;
    localparam int S_B = 18;
    localparam int C_B = 17;
    localparam int B_B = 16;
    localparam int SRD_LSB = 8;
    localparam int SIZE_LSB = 1;
    localparam int EN_B = 0;
    localparam int VALID_B = 4;
    localparam int ADDR_LSB = 5;
    localparam logic [4:0] SIZE_MIN = 5'h04;
    localparam logic [4:0] SUB_MIN = 5'h07;
    // control bits and fault status bits
    localparam int ENA_B = 0;
    localparam int HFNMI_B = 1;
    localparam int PRIVDEF_B = 2;
    localparam int IACC_B = 0;
    localparam int DACC_B = 1;
    localparam int MMARV_B = 7;
    // ==========================================
    // permission codes and cache policy codes
    localparam logic [2:0] AP_NONE = 3'h0;
    localparam logic [2:0] AP_PRW = 3'h1;
    localparam logic [2:0] AP_PRW_URO = 3'h2;
    localparam logic [2:0] AP_FULL = 3'h3;
    localparam logic [2:0] AP_PRO = 3'h5;
    localparam logic [2:0] AP_RO = 3'h6;
    localparam logic [2:0] AP_RO2 = 3'h7;
    localparam logic [1:0] CP_NC = 2'h0;
    localparam logic [1:0] CP_WBWA = 2'h1;
    localparam logic [1:0] CP_WT = 2'h2;
    localparam logic [1:0] CP_WB = 2'h3;
    typedef enum logic [2:0] {MT_STRONG, MT_DEVICE, MT_NORMAL, MT_RESERVED, MT_IMPL} rpd_mtype_e;
endpackage : rpd_pkg

// [rpd_region.sv]
// one region: address match, attribute decode and permission check
`timescale 1ns/1ps
`default_nettype none
module rpd_region (
    input wire logic [26:0] base_i, // region base, address bits 31:5
    input wire logic [31:0] attr_i, // attribute and size word
    input wire logic [31:0] addr_i, // access address
    input wire logic priv_i, // privileged access
    input wire logic write_i, // write access
    input wire logic fetch_i, // instruction fetch
    output logic hit_o, // region matches access
    output logic deny_o, // rights missing
    output var rpd_pkg::rpd_mtype_e mtype_o, // memory type
    output logic share_o, // shareable
    output logic [1:0] outer_o, // outer cache policy
    output logic [1:0] inner_o // inner cache policy
);
    // ==========================================
    // field extraction
    logic [4:0] size_w; // region size is 2^(size+1)
    logic [2:0] tex_w; // type extension field
    logic [2:0] ap_w; // access permission field
    logic [1:0] cb_w; // cacheable, bufferable
    logic [2:0] sub_w; // subregion index of the access
    logic sub_off_w; // subregion disabled
    logic miss; // address outside region
    logic rd_ok; // read right held
    logic wr_ok; // write right held
    assign size_w = attr_i[rpd_pkg::SIZE_LSB +: 5];
    assign tex_w = attr_i[rpd_pkg::TEX_LSB +: 3];
    assign ap_w = attr_i[rpd_pkg::AP_LSB +: 3];
    assign cb_w = {attr_i[rpd_pkg::C_B], attr_i[rpd_pkg::B_B]};
    assign sub_w = 3'(addr_i >> (size_w - 5'h02));
    // small regions have no subregions, their disable bits are ignored
    assign sub_off_w = (size_w >= rpd_pkg::SUB_MIN) && attr_i[rpd_pkg::SRD_LSB + 32'(sub_w)];

    // compare only address bits above the region size
    always_comb begin
        miss = 1'b0;
        for (int i = rpd_pkg::ADDR_LSB; i < 32; i++) begin
            if (i > int'(size_w) && addr_i[i] != base_i[i - rpd_pkg::ADDR_LSB]) miss = 1'b1;
        end
    end
    // sizes below 32 bytes are unusable, so they never match
    assign hit_o = attr_i[rpd_pkg::EN_B] && size_w >= rpd_pkg::SIZE_MIN && !miss && !sub_off_w;

    // ==========================================
    // memory type decode; don't-care bits are simply not looked at
    always_comb begin
        mtype_o = rpd_pkg::MT_RESERVED;
        share_o = attr_i[rpd_pkg::S_B];
        outer_o = rpd_pkg::CP_NC;
        inner_o = rpd_pkg::CP_NC;
        if (tex_w[2]) begin
            mtype_o = rpd_pkg::MT_NORMAL;
            outer_o = tex_w[1:0];
            inner_o = cb_w;
        end else begin
            case (tex_w[1:0])
                2'h0: begin
                    case (cb_w)
                        2'h0: begin
                            mtype_o = rpd_pkg::MT_STRONG;
                            share_o = 1'b1;
                        end
                        2'h1: begin
                            mtype_o = rpd_pkg::MT_DEVICE;
                            share_o = 1'b1;
                        end
                        2'h2: begin
                            mtype_o = rpd_pkg::MT_NORMAL;
                            outer_o = rpd_pkg::CP_WT;
                            inner_o = rpd_pkg::CP_WT;
                        end
                        default: begin
                            mtype_o = rpd_pkg::MT_NORMAL;
                            outer_o = rpd_pkg::CP_WB;
                            inner_o = rpd_pkg::CP_WB;
                        end
                    endcase
                end
                2'h1: begin
                    case (cb_w)
                        2'h0: mtype_o = rpd_pkg::MT_NORMAL;
                        2'h2: mtype_o = rpd_pkg::MT_IMPL;
                        2'h3: begin
                            mtype_o = rpd_pkg::MT_NORMAL;
                            outer_o = rpd_pkg::CP_WBWA;
                            inner_o = rpd_pkg::CP_WBWA;
                        end
                        default: mtype_o = rpd_pkg::MT_RESERVED;
                    endcase
                end
                2'h2: begin
                    mtype_o = (cb_w == 2'h0) ? rpd_pkg::MT_DEVICE : rpd_pkg::MT_RESERVED;
                    share_o = 1'b0;
                end
                default: mtype_o = rpd_pkg::MT_RESERVED;
            endcase
        end
    end

    // ==========================================
    // permission check; the reserved code 100 is treated as no access
    always_comb begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        case (ap_w)
            rpd_pkg::AP_PRW: begin
                rd_ok = priv_i;
                wr_ok = priv_i;
            end
            rpd_pkg::AP_PRW_URO: begin
                rd_ok = 1'b1;
                wr_ok = priv_i;
            end
            rpd_pkg::AP_FULL: begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
            rpd_pkg::AP_PRO: rd_ok = priv_i;
            rpd_pkg::AP_RO, rpd_pkg::AP_RO2: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end
    // execute-never overrides any read right for fetches
    assign deny_o = (write_i ? !wr_ok : !rd_ok) || (fetch_i && attr_i[rpd_pkg::XN_B]);
endmodule : rpd_region
`default_nettype wire

// [rpd_top.sv]
// region permission attribute decoder: register file, region lookup and fault capture
`timescale 1ns/1ps
`default_nettype none
module rpd_top #(
    parameter int NREG = 8 // number of regions
) (
    input wire logic CLK_SYS_I, // processor clock
    input wire logic RESETN_I, // async reset, active low
    input wire logic PPB_SEL_I, // register access strobe
    input wire logic PPB_WR_I, // 1 write, 0 read
    input wire logic [31:0] PPB_ADDR_I, // byte address, word aligned
    input wire logic [3:0] PPB_BE_I, // byte lane enables
    input wire logic [31:0] PPB_WDATA_I, // write data
    output logic [31:0] PPB_RDATA_O, // read data, cycle after read
    input wire logic ACC_VALID_I, // access to be checked
    input wire logic [31:0] ACC_ADDR_I, // access address
    input wire logic ACC_WRITE_I, // access is a write
    input wire logic ACC_PRIV_I, // access is privileged
    input wire logic ACC_FETCH_I, // access is an instruction fetch
    input wire logic ACC_ESC_I, // core in hard fault or nmi handler
    output logic ACC_DONE_O, // result valid pulse
    output logic ACC_FAULT_O, // access denied
    output logic [2:0] ACC_MTYPE_O, // memory type
    output logic ACC_SHARE_O, // shareable
    output logic [1:0] ACC_OUTER_O, // outer cache policy
    output logic [1:0] ACC_INNER_O, // inner cache policy
    output logic MMFAULT_O, // fault pulse to exception logic
    output logic [7:0] FAULT_STATUS_O, // sticky fault cause
    output logic [31:0] FAULT_ADDR_O // address of last data fault
);
    localparam int RW = $clog2(NREG); // region number width

    // ==========================================
    // state
    logic [2:0] ctrl_r; // privdef, hfnmi, enable
    logic [RW-1:0] rnr_r; // selected region
    logic [26:0] base_r [NREG]; // region base addresses
    logic [31:0] attr_r [NREG]; // region attribute and size words
    logic [7:0] fstat_r; // fault status
    logic [7:0] fstat_nxt; // next fault status

    // ==========================================
    // register decode
    logic wr_w; // write strobe
    logic full_w; // whole word written
    logic in_alias_w; // address within base/attribute window
    logic hit_ctrl_w; // control register
    logic hit_sel_w; // region select register
    logic hit_base_w; // base register or alias
    logic hit_attr_w; // attribute register or alias
    logic hit_type_w; // type register
    logic hit_fst_w; // fault status
    logic base_valid_w; // base write carries region number
    logic [RW-1:0] base_idx_w; // region the base write targets
    logic [31:0] rd_w; // read mux output
    assign wr_w = PPB_SEL_I && PPB_WR_I;
    // only the attribute word and the fault status may be written in bytes or halves
    assign full_w = PPB_BE_I == 4'hf;
    assign in_alias_w = PPB_ADDR_I >= rpd_pkg::ADDR_BASE && PPB_ADDR_I <= rpd_pkg::ADDR_ALIAS_END;
    assign hit_ctrl_w = PPB_ADDR_I == rpd_pkg::ADDR_CTRL;
    assign hit_sel_w = PPB_ADDR_I == rpd_pkg::ADDR_SEL;
    // aliases alternate base/attribute every four bytes
    assign hit_base_w = in_alias_w && PPB_ADDR_I[2] == rpd_pkg::ADDR_BASE[2];
    assign hit_attr_w = in_alias_w && PPB_ADDR_I[2] == rpd_pkg::ADDR_ATTR[2];
    assign hit_type_w = PPB_ADDR_I == rpd_pkg::ADDR_TYPE;
    assign hit_fst_w = PPB_ADDR_I == rpd_pkg::ADDR_FSTAT;
    // region numbers beyond the last region are ignored
    assign base_valid_w = PPB_WDATA_I[rpd_pkg::VALID_B] && 32'(PPB_WDATA_I[3:0]) < NREG;
    assign base_idx_w = base_valid_w ? PPB_WDATA_I[RW-1:0] : rnr_r;
    assign rd_w = hit_type_w ? rpd_pkg::TYPE_VAL :
                  hit_ctrl_w ? {29'h0, ctrl_r} :
                  hit_sel_w ? 32'(rnr_r) :
                  hit_base_w ? {base_r[rnr_r], 1'b0, 4'(rnr_r)} :
                  hit_attr_w ? attr_r[rnr_r] :
                  hit_fst_w ? {24'h0, fstat_r} : rpd_pkg::RST_WORD;

    // ==========================================
    // control and region select
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_r <= 3'h0;
            rnr_r <= '0;
        end else if (wr_w && full_w) begin
            if (hit_ctrl_w) ctrl_r <= PPB_WDATA_I[2:0];
            if (hit_sel_w) rnr_r <= PPB_WDATA_I[RW-1:0];
            if (hit_base_w && base_valid_w) rnr_r <= PPB_WDATA_I[RW-1:0];
        end
    end

    // ==========================================
    // region table; a write lands in one cycle and the very next
    // access already sees it, so no ordering hazard exists here
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < NREG; i++) begin
                base_r[i] <= '0;
                attr_r[i] <= rpd_pkg::RST_WORD;
            end
        end else if (wr_w) begin
            if (hit_base_w && full_w) base_r[base_idx_w] <= PPB_WDATA_I[31:5];
            for (int b = 0; b < 4; b++) begin
                if (hit_attr_w && PPB_BE_I[b])
                    attr_r[rnr_r][8*b +: 8] <= PPB_WDATA_I[8*b +: 8] & rpd_pkg::ATTR_MASK[8*b +: 8];
            end
        end
    end

    // ==========================================
    // per-region lookup
    logic [NREG-1:0] hit_w; // region hits
    logic [NREG-1:0] deny_w; // region denials
    logic [NREG-1:0] share_w; // region shareability
    rpd_pkg::rpd_mtype_e mt_w [NREG]; // region memory types
    logic [1:0] out_w [NREG]; // region outer policies
    logic [1:0] in_w [NREG]; // region inner policies
    for (genvar g = 0; g < NREG; g++) begin : g_reg
        rpd_region u_reg (
            .base_i(base_r[g]),
            .attr_i(attr_r[g]),
            .addr_i(ACC_ADDR_I),
            .priv_i(ACC_PRIV_I),
            .write_i(ACC_WRITE_I),
            .fetch_i(ACC_FETCH_I),
            .hit_o(hit_w[g]),
            .deny_o(deny_w[g]),
            .mtype_o(mt_w[g]),
            .share_o(share_w[g]),
            .outer_o(out_w[g]),
            .inner_o(in_w[g])
        );
    end

    // ==========================================
    // highest-numbered hit wins, later regions overwrite earlier ones
    logic win_hit; // some region matched
    logic [RW-1:0] win_idx; // winning region
    always_comb begin
        win_hit = 1'b0;
        win_idx = '0;
        for (int i = 0; i < NREG; i++) begin
            if (hit_w[i]) begin
                win_hit = 1'b1;
                win_idx = RW'(i);
            end
        end
    end

    // ==========================================
    // access decision; one map serves fetches and data alike
    logic mpu_on_w; // protection active for this access
    logic bg_ok_w; // background map usable
    logic fault_w; // access denied
    logic [2:0] ap_win_w; // winner permission code
    logic [5:0] tcb_win_w; // winner type, shareable, cacheable, bufferable
    assign mpu_on_w = ctrl_r[rpd_pkg::ENA_B] && !(ACC_ESC_I && !ctrl_r[rpd_pkg::HFNMI_B]);
    assign bg_ok_w = ACC_PRIV_I && ctrl_r[rpd_pkg::PRIVDEF_B];
    assign fault_w = mpu_on_w && (win_hit ? deny_w[win_idx] : !bg_ok_w);
    assign ap_win_w = attr_r[win_idx][rpd_pkg::AP_LSB +: 3];
    assign tcb_win_w = attr_r[win_idx][rpd_pkg::B_B +: 6];

    // ==========================================
    // result registers; outside any region the default normal
    // attributes stand, a simplification of the full default map
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ACC_DONE_O <= 1'b0;
            ACC_FAULT_O <= 1'b0;
            ACC_MTYPE_O <= 3'h0;
            ACC_SHARE_O <= 1'b0;
            ACC_OUTER_O <= 2'h0;
            ACC_INNER_O <= 2'h0;
            MMFAULT_O <= 1'b0;
        end else begin
            ACC_DONE_O <= ACC_VALID_I;
            ACC_FAULT_O <= ACC_VALID_I && fault_w;
            MMFAULT_O <= ACC_VALID_I && fault_w;
            if (ACC_VALID_I && mpu_on_w && win_hit) begin
                ACC_MTYPE_O <= mt_w[win_idx];
                ACC_SHARE_O <= share_w[win_idx];
                ACC_OUTER_O <= out_w[win_idx];
                ACC_INNER_O <= in_w[win_idx];
            end else if (ACC_VALID_I) begin
                ACC_MTYPE_O <= rpd_pkg::MT_NORMAL;
                ACC_SHARE_O <= 1'b0;
                ACC_OUTER_O <= rpd_pkg::CP_WT;
                ACC_INNER_O <= rpd_pkg::CP_WT;
            end
        end
    end

    // ==========================================
    // fault status: write one to clear, a new fault in the same cycle wins
    always_comb begin
        fstat_nxt = fstat_r;
        if (wr_w && hit_fst_w && PPB_BE_I[0]) fstat_nxt = fstat_r & ~PPB_WDATA_I[7:0];
        if (ACC_VALID_I && fault_w) begin
            if (ACC_FETCH_I) fstat_nxt[rpd_pkg::IACC_B] = 1'b1;
            else begin
                fstat_nxt[rpd_pkg::DACC_B] = 1'b1;
                fstat_nxt[rpd_pkg::MMARV_B] = 1'b1;
            end
        end
    end
    assign FAULT_STATUS_O = fstat_r;

    // status, fault address and read data
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fstat_r <= 8'h00;
            FAULT_ADDR_O <= rpd_pkg::RST_WORD;
            PPB_RDATA_O <= rpd_pkg::RST_WORD;
        end else begin
            fstat_r <= fstat_nxt;
            if (ACC_VALID_I && fault_w && !ACC_FETCH_I) FAULT_ADDR_O <= ACC_ADDR_I;
            if (PPB_SEL_I && !PPB_WR_I) PPB_RDATA_O <= rd_w;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RESETN_I);

    AST_DONE: assert property (ACC_VALID_I |=> ACC_DONE_O)
        else $error("access result missing");
    AST_OFF_NOFAULT: assert property (
        ACC_VALID_I && !ctrl_r[rpd_pkg::ENA_B] |=> !ACC_FAULT_O)
        else $error("fault while protection disabled");
    AST_AP_NONE: assert property (
        ACC_VALID_I && mpu_on_w && win_hit && ap_win_w == rpd_pkg::AP_NONE |=> ACC_FAULT_O)
        else $error("no-access region did not fault");
    AST_AP_RO_WR: assert property (ACC_VALID_I && mpu_on_w && win_hit && ACC_WRITE_I
        && ap_win_w[2:1] == rpd_pkg::AP_RO[2:1] |=> ACC_FAULT_O)
        else $error("write to read-only region passed");
    AST_AP_USR_RD: assert property (ACC_VALID_I && mpu_on_w && win_hit && !ACC_WRITE_I
        && !ACC_FETCH_I && ap_win_w == rpd_pkg::AP_PRW_URO |=> !ACC_FAULT_O)
        else $error("read of readable region faulted");
    AST_XN: assert property (ACC_VALID_I && mpu_on_w && win_hit && ACC_FETCH_I
        && attr_r[win_idx][rpd_pkg::XN_B] |=> ACC_FAULT_O)
        else $error("fetch from execute-never region passed");
    AST_PRIO: assert property (hit_w[NREG-1] |-> win_idx == RW'(NREG - 1))
        else $error("top region lost priority");
    AST_STRONG: assert property (ACC_VALID_I && mpu_on_w && win_hit && tcb_win_w[5:0] == 6'h00
        |=> ACC_MTYPE_O == rpd_pkg::MT_STRONG && ACC_SHARE_O)
        else $error("strongly-ordered decode wrong");
    AST_FAULT_REC: assert property (
        MMFAULT_O |-> (FAULT_STATUS_O[rpd_pkg::IACC_B] || FAULT_STATUS_O[rpd_pkg::DACC_B]))
        else $error("fault without recorded cause");
    AST_STICKY: assert property (FAULT_STATUS_O[rpd_pkg::DACC_B] && !(wr_w && hit_fst_w)
        |=> FAULT_STATUS_O[rpd_pkg::DACC_B])
        else $error("fault status lost");
    AST_VALID_SEL: assert property (wr_w && full_w && hit_base_w && base_valid_w
        |=> rnr_r == RW'($past(PPB_WDATA_I)))
        else $error("base write did not select region");
    AST_TYPE_RD: assert property (PPB_SEL_I && !PPB_WR_I && hit_type_w
        |=> PPB_RDATA_O == rpd_pkg::TYPE_VAL)
        else $error("type register read wrong");

    COV_FAULT: cover property (ACC_VALID_I ##1 MMFAULT_O);
    COV_OVERLAP: cover property (ACC_VALID_I && hit_w[0] && hit_w[NREG-1]);
    COV_ALIAS: cover property (wr_w && hit_base_w && base_valid_w ##1 wr_w && hit_attr_w);
    COV_BG: cover property (ACC_VALID_I && mpu_on_w && !win_hit && bg_ok_w);
endmodule : rpd_top
`default_nettype wire

// [rpd_core.sv]
// core model: register bus and access master
`timescale 1ns/1ps
`default_nettype none
module rpd_core (
    input wire logic clk_i, // clock
    input wire logic [31:0] rd_i, // read data
    output logic sel_o, // reg strobe
    output logic wr_o, // reg write
    output logic [31:0] ad_o, // reg address
    output logic [3:0] be_o, // lanes
    output logic [31:0] wd_o, // write data
    output logic av_o, // access valid
    output logic [31:0] aa_o, // access address
    output logic [2:0] ak_o, // write, priv, fetch
    output logic esc_o // escalated handler
);
    // ==========================================
    // released address and data lines show inverted values so stale data never passes
    initial {sel_o, wr_o, ad_o, be_o, wd_o, av_o, aa_o, ak_o, esc_o} = '0;
    // one register cycle, taken at the rising edge in between
    task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] b,
                       output logic [31:0] q);
        @(negedge clk_i);
        {sel_o, wr_o, ad_o, be_o, wd_o} = {1'b1, w, a, b, d};
        // returning after the taking edge makes every write a barrier
        @(negedge clk_i);
        q = rd_i;
        {sel_o, ad_o, wd_o} = {1'b0, ~a, ~d};
    endtask : bus
    // one checked access, answer one cycle later
    task automatic acc(input logic [31:0] a, input logic [2:0] k);
        @(negedge clk_i);
        {av_o, aa_o, ak_o} = {1'b1, a, k};
        @(negedge clk_i);
        {av_o, aa_o} = {1'b0, ~a};
    endtask : acc
    // escalated handler level, changed only between accesses
    task automatic esc(input logic e);
        @(negedge clk_i);
        esc_o = e;
    endtask : esc
endmodule : rpd_core
`default_nettype wire

// [region_permission_attribute_decoder_bench.sv]
// bench for the region permission attribute decoder
`timescale 1ns/1ps
`default_nettype none
module region_permission_attribute_decoder_bench;
    // ==========================================
    logic clk = 1'b0; // 20 MHz
    logic rstn = 1'b0; // reset, active low
    logic sel, wr, av, esc, done, flt, mmf, sh;
    logic [31:0] ad, wd, rd, aa, fa, q;
    logic [3:0] be;
    logic [2:0] ak, mt;
    logic [1:0] outr, inr;
    logic [7:0] fs;
    int error_cnt = 0;
    int checks = 0;
    initial forever #25 clk = ~clk;
    rpd_core i_core (.clk_i(clk), .rd_i(rd), .sel_o(sel), .wr_o(wr), .ad_o(ad), .be_o(be),
        .wd_o(wd), .av_o(av), .aa_o(aa), .ak_o(ak), .esc_o(esc));
    rpd_top i_dut (.CLK_SYS_I(clk), .RESETN_I(rstn), .PPB_SEL_I(sel), .PPB_WR_I(wr),
        .PPB_ADDR_I(ad), .PPB_BE_I(be), .PPB_WDATA_I(wd), .PPB_RDATA_O(rd), .ACC_VALID_I(av),
        .ACC_ADDR_I(aa), .ACC_WRITE_I(ak[2]), .ACC_PRIV_I(ak[1]), .ACC_FETCH_I(ak[0]),
        .ACC_ESC_I(esc), .ACC_DONE_O(done), .ACC_FAULT_O(flt), .ACC_MTYPE_O(mt),
        .ACC_SHARE_O(sh), .ACC_OUTER_O(outr), .ACC_INNER_O(inr), .MMFAULT_O(mmf),
        .FAULT_STATUS_O(fs), .FAULT_ADDR_O(fa));
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("ERROR %0t ns: %s", $time, m);
        end
    endtask : chk
    task automatic w(input logic [31:0] a, d, input logic [3:0] b = 4'hf);
        i_core.bus(1'b1, a, d, b, q);
    endtask : w
    task automatic r(input logic [31:0] a, e, input string m);
        i_core.bus(1'b0, a, 32'h0, 4'hf, q);
        chk(q === e, m);
    endtask : r
    // attribute word for a 1 kB enabled region
    function automatic logic [31:0] attr_w(input logic x, input logic [2:0] p, t, scb);
        return {3'h0, x, 1'b0, p, 2'h0, t, scb, 8'h00, 8'h13};
    endfunction : attr_w
    // disabled first so a half-written region never governs an access
    task automatic prog(input logic [31:0] n, v);
        w(rpd_pkg::ADDR_SEL, n);
        w(rpd_pkg::ADDR_ATTR, v & 32'hfffffffe, 4'h3);
        w(rpd_pkg::ADDR_BASE, 32'h20000000);
        w(rpd_pkg::ADDR_ATTR, v, 4'hc);
        w(rpd_pkg::ADDR_ATTR, v, 4'h3);
    endtask : prog
    task automatic acc(input logic [2:0] k, input logic f, input logic [31:0] a = 32'h20000010);
        i_core.acc(a, k);
        chk(done === 1'b1 && flt === f && mmf === f, "access result");
        if (f && !k[0]) chk(fs[1] === 1'b1 && fs[7] === 1'b1 && fa === a, "cause");
    endtask : acc
    task automatic dec(input logic [2:0] t, scb, emt, input logic esh, input logic [3:0] pol);
        prog(0, attr_w(1'b0, 3'h3, t, scb));
        acc(3'b010, 1'b0);
        chk(mt === emt, "memory type");
        if (emt < 3'h3) chk(sh === esh, "share");
        if (emt == 3'h2) chk({outr, inr} === pol, "policy");
    endtask : dec
    task automatic t_regs;
        r(rpd_pkg::ADDR_TYPE, rpd_pkg::TYPE_VAL, "type word");
        w(rpd_pkg::ADDR_TYPE, 32'h0);
        r(rpd_pkg::ADDR_TYPE, rpd_pkg::TYPE_VAL, "type write");
        r(32'he000ed80, 32'h0, "unmapped");
        r(rpd_pkg::ADDR_SEL, 32'h0, "select reset");
        w(rpd_pkg::ADDR_CTRL, 32'h1);
    endtask : t_regs
    // every permission code against the four kinds of data access
    task automatic t_perm;
        logic [3:0] fm [8] = '{4'hf, 4'h3, 4'h1, 4'h0, 4'hf, 4'h7, 4'h5, 4'h5};
        for (int c = 0; c < 8; c++) begin
            prog(0, attr_w(1'b0, 3'(c), 3'h0, 3'b010));
            for (int j = 0; j < 4; j++) acc({j[0], ~j[1], 1'b0}, fm[c][3 - j]);
        end
    endtask : t_perm
    task automatic t_xn;
        prog(0, attr_w(1'b1, 3'h3, 3'h0, 3'b010));
        w(rpd_pkg::ADDR_FSTAT, 32'hff, 4'h1);
        chk(fs === 8'h00, "status clear");
        acc(3'b011, 1'b1);
        chk(fs === 8'h01, "fetch cause");
        acc(3'b010, 1'b0);
    endtask : t_xn
    task automatic t_over;
        prog(0, attr_w(1'b0, 3'h3, 3'h0, 3'b010));
        w(rpd_pkg::ADDR_BASE, 32'h20000017);
        r(rpd_pkg::ADDR_SEL, 32'h7, "select");
        r(rpd_pkg::ADDR_BASE, 32'h20000007, "base");
        w(32'he000edb8, attr_w(1'b0, 3'h0, 3'h0, 3'b010));
        acc(3'b010, 1'b1);
        // subregion 0 of region 7 off: region 0 shows through
        w(rpd_pkg::ADDR_ATTR, 32'h00000100, 4'h2);
        acc(3'b010, 1'b0);
        // escalated handler bypasses the unit unless hfnmi is set
        i_core.esc(1'b1);
        acc(3'b010, 1'b0, 32'h20000200);
        w(rpd_pkg::ADDR_CTRL, 32'h3);
        acc(3'b010, 1'b1, 32'h20000200);
        i_core.esc(1'b0);
        // background map: privileged only
        w(rpd_pkg::ADDR_CTRL, 32'h5);
        acc(3'b010, 1'b0, 32'h30000000);
        acc(3'b000, 1'b1, 32'h30000000);
    endtask : t_over
    task automatic final_report;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        t_regs();
        t_perm();
        dec(3'h0, 3'b000, 3'h0, 1'b1, 4'h0);
        dec(3'h0, 3'b101, 3'h1, 1'b1, 4'h0);
        dec(3'h2, 3'b100, 3'h1, 1'b0, 4'h0);
        dec(3'h0, 3'b110, 3'h2, 1'b1, 4'ha);
        dec(3'h0, 3'b011, 3'h2, 1'b0, 4'hf);
        dec(3'h1, 3'b100, 3'h2, 1'b1, 4'h0);
        dec(3'h1, 3'b001, 3'h3, 1'b0, 4'h0);
        dec(3'h1, 3'b010, 3'h4, 1'b0, 4'h0);
        dec(3'h1, 3'b011, 3'h2, 1'b0, 4'h5);
        dec(3'h5, 3'b110, 3'h2, 1'b1, 4'h6);
        t_xn();
        t_over();
        final_report();
    end
    // watchdog: all tasks need well under 2000 cycles
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule : region_permission_attribute_decoder_bench
`default_nettype wire
